//--- pkg/uart_channel_defines.svh
`ifndef UART_CHANNEL_DEFINES_SVH
`define UART_CHANNEL_DEFINES_SVH

`define CMD_OFFSET      4'h0
`define CLKSEL_OFFSET   4'h4
`define STATUS_OFFSET   4'h8
`define MODE1_OFFSET    4'hC

`define CMD_CODE_MSB    7
`define CMD_CODE_LSB    4
`define CMD_TX_DIS      3
`define CMD_TX_EN       2
`define CMD_RX_DIS      1
`define CMD_RX_EN       0
`define MODE1_PAR_MSB   4
`define MODE1_PAR_LSB   3
`define PAR_WAKE_UP     2'h3

`define CLKSEL_RESET    8'h00
`define MODE1_RESET     8'h00
`define FIFO_DEPTH      4'h8

`endif

//--- pkg/uart_channel_pkg.sv
package uart_channel_pkg;

  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_PTR_ONE   = 4'h1,
    CMD_RST_RX    = 4'h2,
    CMD_RST_TX    = 4'h3,
    CMD_RST_ERR   = 4'h4,
    CMD_RST_BRKCH = 4'h5,
    CMD_BRK_START = 4'h6,
    CMD_BRK_STOP  = 4'h7,
    CMD_RTS_ON    = 4'h8,
    CMD_RTS_OFF   = 4'h9,
    CMD_TMO_ON    = 4'hA,
    CMD_PTR_ZERO  = 4'hB,
    CMD_TMO_OFF   = 4'hC,
    CMD_BLK_ERR   = 4'hD,
    CMD_TEST_E    = 4'hE,
    CMD_TEST_F    = 4'hF
  } cmd_e;

  typedef enum logic [1:0] {
    BRK_IDLE = 2'b00,
    BRK_WAIT = 2'b01,
    BRK_ON   = 2'b10,
    BRK_MARK = 2'b11
  } break_state_e;

  typedef enum logic [1:0] {
    SRC_RATE_GEN = 2'b00,
    SRC_TIMER   = 2'b01,
    SRC_PIN_16X = 2'b10,
    SRC_PIN_1X  = 2'b11
  } clk_source_e;

  typedef struct packed {
    logic [7:0]       clksel;
    logic [7:0]       mode1;
    logic [31:0]      prdata;
    logic             rx_en;
    logic             tx_en;
    logic             tx_pend;
    logic             tx_empty;
    logic [3:0]       tx_cnt;
    logic [3:0]       rx_cnt;
    logic             held;
    logic [2:0]       held_err;
    logic [2:0]       rd_ptr;
    logic [2:0]       wr_ptr;
    logic [7:0][2:0]  err_mem;
    logic [2:0]       blk_err;
    logic             overrun;
    logic             brk_block;
    logic             brk_chg;
    logic             blk_mode;
    logic             tmo_mode;
    logic             mr_ptr;
    logic             rts_n;
    break_state_e     brk_st;
    logic             rx_rst;
    logic             tx_rst;
    logic             hunt;
    logic             ctr_stop;
    logic             ctr_rclr;
    logic             restart;
  } chan_state_s;

endpackage : uart_channel_pkg

//--- rtl/clock_select_decode.sv
`timescale 1ns/1ps
`default_nettype none

module clock_select_decode (
  input  wire logic [3:0]              code,
  input  wire logic                    rate_set,
  output var uart_channel_pkg::clk_source_e src,
  output logic [15:0]                  baud
);

  // Nibble codes 1101 to 1111 leave the rate generator; the rest name a rate.
  always_comb begin
    case (code)
      4'hD:    src = uart_channel_pkg::SRC_TIMER;
      4'hE:    src = uart_channel_pkg::SRC_PIN_16X;
      4'hF:    src = uart_channel_pkg::SRC_PIN_1X;
      default: src = uart_channel_pkg::SRC_RATE_GEN;
    endcase
  end

  // Both rate sets of the generator, chosen by rate_set, from a 3.6864 MHz reference.
  always_comb begin
    case (code)
      4'h0:    baud = rate_set ? 16'h004B : 16'h0032;
      4'h1:    baud = 16'h006E;
      4'h2:    baud = rate_set ? 16'h9600 : 16'h0086;
      4'h3:    baud = rate_set ? 16'h0096 : 16'h00C8;
      4'h4:    baud = 16'h012C;
      4'h5:    baud = 16'h0258;
      4'h6:    baud = 16'h04B0;
      4'h7:    baud = rate_set ? 16'h07D0 : 16'h041A;
      4'h8:    baud = 16'h0960;
      4'h9:    baud = 16'h12C0;
      4'hA:    baud = rate_set ? 16'h0708 : 16'h1C20;
      4'hB:    baud = 16'h2580;
      4'hC:    baud = rate_set ? 16'h4B00 : 16'h9600;
      default: baud = 16'h0000;
    endcase
  end

endmodule : clock_select_decode

`default_nettype wire

//--- rtl/uart_channel_command_status.sv
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "uart_channel_defines.svh"

module uart_channel_command_status (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [3:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_char_valid,
  input  wire logic        rx_char_break,
  input  wire logic        rx_char_parity_err,
  input  wire logic        rx_char_frame_err,
  input  wire logic        rx_char_ad_bit,
  input  wire logic        rx_fifo_read,
  input  wire logic        rx_line_mark_half,
  input  wire logic        peer_rx_load,
  input  wire logic        tx_load,
  input  wire logic        tx_char_taken,
  input  wire logic        tx_char_sent,
  input  wire logic        tx_bit_tick,
  input  wire logic        rate_set,
  output logic             rx_enable,
  output logic             rx_active,
  output logic             tx_enable,
  output logic             transmit_ready_flag,
  output logic             rx_reset,
  output logic             tx_reset,
  output logic             rx_hunt_start,
  output logic             tx_force_space,
  output logic             tx_hold_mark,
  output logic             request_to_send_out_n,
  output logic             mr_pointer,
  output logic             timeout_mode,
  output logic             counter_stop,
  output logic             counter_ready_clear,
  output logic             counter_restart,
  output logic             block_error_mode,
  output logic             break_change,
  output logic             wake_up_mode,
  output logic [1:0]       rx_clk_src,
  output logic [1:0]       tx_clk_src,
  output logic [15:0]      rx_baud,
  output logic [15:0]      tx_baud
);

  localparam uart_channel_pkg::chan_state_s ST_RST = '{
    clksel:  `CLKSEL_RESET,
    mode1:   `MODE1_RESET,
    rts_n:   1'b1,
    brk_st:  uart_channel_pkg::BRK_IDLE,
    default: '0
  };

  uart_channel_pkg::chan_state_s st_r;
  uart_channel_pkg::chan_state_s st_nxt;
  uart_channel_pkg::cmd_e        cmd_code;
  uart_channel_pkg::clk_source_e rx_src;
  uart_channel_pkg::clk_source_e tx_src;

  logic       wr_access;
  logic       cmd_wr;
  logic       mapped;
  logic       wake;
  logic       tx_ready;
  logic [2:0] head_err;
  logic [2:0] new_err;
  logic [7:0] status;

  // The bus never waits: setup latches read data, access completes.
  assign pready    = 1'b1;
  assign mapped    = (paddr == `CMD_OFFSET) || (paddr == `CLKSEL_OFFSET) ||
                     (paddr == `STATUS_OFFSET) || (paddr == `MODE1_OFFSET);
  assign pslverr   = psel && penable && !mapped;
  assign wr_access = psel && penable && pwrite && mapped;
  assign cmd_wr    = wr_access && (paddr == `CMD_OFFSET);
  assign cmd_code  = uart_channel_pkg::cmd_e'(pwdata[`CMD_CODE_MSB:`CMD_CODE_LSB]);

  assign wake = (st_r.mode1[`MODE1_PAR_MSB:`MODE1_PAR_LSB] == `PAR_WAKE_UP);
  assign tx_ready = st_r.tx_en && !st_r.tx_pend && (st_r.tx_cnt < `FIFO_DEPTH);
  assign head_err = (st_r.rx_cnt != 4'h0) ? st_r.err_mem[st_r.rd_ptr] : 3'h0;
  assign new_err  = {rx_char_break, rx_char_frame_err,
                     wake ? rx_char_ad_bit : rx_char_parity_err};

  // Break, framing and parity (the address bit in wake-up mode) follow the head character or the block sum.
  assign status = {st_r.blk_mode ? st_r.blk_err : head_err, st_r.overrun,
                   st_r.tx_empty, tx_ready,
                   st_r.rx_cnt == `FIFO_DEPTH, st_r.rx_cnt != 4'h0};

  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_rst   = 1'b0;
    st_nxt.tx_rst   = 1'b0;
    st_nxt.hunt     = 1'b0;
    st_nxt.ctr_stop = 1'b0;
    st_nxt.ctr_rclr = 1'b0;
    st_nxt.restart  = 1'b0;

    if (psel && !penable) begin
      case (paddr)
        `STATUS_OFFSET: st_nxt.prdata = {24'h000000, status};
        `MODE1_OFFSET:  st_nxt.prdata = {24'h000000, st_r.mode1};
        default:        st_nxt.prdata = 32'h00000000;
      endcase
    end
    if (wr_access && (paddr == `CLKSEL_OFFSET)) begin
      st_nxt.clksel = pwdata[7:0];
    end
    if (wr_access && (paddr == `MODE1_OFFSET)) begin
      st_nxt.mode1 = pwdata[7:0];
    end

    // Clears come before the events so that a new event wins.
    if (cmd_wr && (cmd_code == uart_channel_pkg::CMD_RST_ERR)) begin
      st_nxt.blk_err = 3'h0;
      st_nxt.overrun = 1'b0;
      st_nxt.err_mem[st_r.rd_ptr] = 3'h0;
    end
    if (cmd_wr && (cmd_code == uart_channel_pkg::CMD_RST_BRKCH)) begin
      st_nxt.brk_chg = 1'b0;
    end

    // A read frees one entry; a waiting character moves in behind it.
    if (rx_fifo_read && (st_nxt.rx_cnt != 4'h0)) begin
      st_nxt.rd_ptr = st_nxt.rd_ptr + 3'h1;
      if (st_nxt.held) begin
        st_nxt.err_mem[st_nxt.wr_ptr] = st_nxt.held_err;
        st_nxt.wr_ptr  = st_nxt.wr_ptr + 3'h1;
        st_nxt.blk_err = st_nxt.blk_err | st_nxt.held_err;
        st_nxt.held    = 1'b0;
        st_nxt.restart = st_r.tmo_mode;
      end else begin
        st_nxt.rx_cnt = st_nxt.rx_cnt - 4'h1;
      end
    end

    if (st_r.brk_block && rx_line_mark_half) begin
      st_nxt.brk_block = 1'b0;
      st_nxt.brk_chg   = 1'b1;
    end
    if (rx_char_valid && (st_r.rx_en || wake) && !st_r.brk_block) begin
      if (rx_char_break) begin
        st_nxt.brk_block = 1'b1;
        st_nxt.brk_chg   = 1'b1;
      end
      if (st_nxt.rx_cnt < `FIFO_DEPTH) begin
        st_nxt.err_mem[st_nxt.wr_ptr] = new_err;
        st_nxt.wr_ptr  = st_nxt.wr_ptr + 3'h1;
        st_nxt.rx_cnt  = st_nxt.rx_cnt + 4'h1;
        st_nxt.blk_err = st_nxt.blk_err | new_err;
        st_nxt.restart = st_r.tmo_mode;
      end else if (!st_nxt.held) begin
        st_nxt.held     = 1'b1;
        st_nxt.held_err = new_err;
      end else begin
        st_nxt.held_err = new_err;
        st_nxt.overrun  = 1'b1;
      end
    end
    if (peer_rx_load && st_r.tmo_mode) begin
      st_nxt.restart = 1'b1;
    end

    // Transmitter queue bookkeeping.
    if (tx_char_taken && (st_nxt.tx_cnt != 4'h0)) begin
      st_nxt.tx_cnt = st_nxt.tx_cnt - 4'h1;
    end
    if (tx_load && tx_ready) begin
      st_nxt.tx_cnt   = st_nxt.tx_cnt + 4'h1;
      st_nxt.tx_empty = 1'b0;
    end
    if (tx_char_sent && (st_nxt.tx_cnt == 4'h0)) begin
      if (st_r.tx_pend) begin
        st_nxt.tx_en    = 1'b0;
        st_nxt.tx_pend  = 1'b0;
        st_nxt.tx_empty = 1'b0;
      end else if (st_r.tx_en) begin
        st_nxt.tx_empty = 1'b1;
      end
    end

    // Break generator.
    case (st_r.brk_st)
      uart_channel_pkg::BRK_IDLE: begin
        st_nxt.brk_st = uart_channel_pkg::BRK_IDLE;
      end
      uart_channel_pkg::BRK_WAIT: begin
        if (st_r.tx_empty && tx_bit_tick) begin
          st_nxt.brk_st = uart_channel_pkg::BRK_ON;
        end
      end
      uart_channel_pkg::BRK_ON: begin
        st_nxt.brk_st = uart_channel_pkg::BRK_ON;
      end
      uart_channel_pkg::BRK_MARK: begin
        if (tx_bit_tick) begin
          st_nxt.brk_st = uart_channel_pkg::BRK_IDLE;
        end
      end
      default: begin
        st_nxt.brk_st = uart_channel_pkg::BRK_IDLE;
      end
    endcase

    // Command field; every action of one write is taken together.
    if (cmd_wr) begin
      case (cmd_code)
        uart_channel_pkg::CMD_PTR_ONE: st_nxt.mr_ptr = 1'b1;
        uart_channel_pkg::CMD_PTR_ZERO: st_nxt.mr_ptr = 1'b0;
        uart_channel_pkg::CMD_RST_RX: begin
          st_nxt.rx_en     = 1'b0;
          st_nxt.rx_cnt    = 4'h0;
          st_nxt.rd_ptr    = 3'h0;
          st_nxt.wr_ptr    = 3'h0;
          st_nxt.held      = 1'b0;
          st_nxt.blk_err   = 3'h0;
          st_nxt.overrun   = 1'b0;
          st_nxt.brk_block = 1'b0;
          st_nxt.blk_mode  = 1'b0;
          st_nxt.rx_rst    = 1'b1;
        end
        uart_channel_pkg::CMD_RST_TX: begin
          st_nxt.tx_en    = 1'b0;
          st_nxt.tx_pend  = 1'b0;
          st_nxt.tx_cnt   = 4'h0;
          st_nxt.tx_empty = 1'b0;
          st_nxt.brk_st   = uart_channel_pkg::BRK_IDLE;
          st_nxt.tx_rst   = 1'b1;
        end
        uart_channel_pkg::CMD_BRK_START: begin
          if (st_r.tx_en && (st_r.brk_st == uart_channel_pkg::BRK_IDLE)) begin
            st_nxt.brk_st = uart_channel_pkg::BRK_WAIT;
          end
        end
        uart_channel_pkg::CMD_BRK_STOP: begin
          if (st_r.brk_st == uart_channel_pkg::BRK_ON) begin
            st_nxt.brk_st = uart_channel_pkg::BRK_MARK;
          end else if (st_r.brk_st == uart_channel_pkg::BRK_WAIT) begin
            st_nxt.brk_st = uart_channel_pkg::BRK_IDLE;
          end
        end
        uart_channel_pkg::CMD_RTS_ON:  st_nxt.rts_n = 1'b0;
        uart_channel_pkg::CMD_RTS_OFF: st_nxt.rts_n = 1'b1;
        uart_channel_pkg::CMD_TMO_ON: begin
          st_nxt.tmo_mode = 1'b1;
          st_nxt.ctr_stop = 1'b1;
          st_nxt.ctr_rclr = 1'b1;
        end
        uart_channel_pkg::CMD_TMO_OFF: st_nxt.tmo_mode = 1'b0;
        uart_channel_pkg::CMD_BLK_ERR: st_nxt.blk_mode = 1'b1;
        default: st_nxt.mr_ptr = st_nxt.mr_ptr;
      endcase
      // Only an underrun stops at once; the queued characters and the one in flight still go out.
      if (pwdata[`CMD_TX_DIS] && st_nxt.tx_en) begin
        if (st_nxt.tx_empty) begin
          st_nxt.tx_en   = 1'b0;
          st_nxt.tx_pend = 1'b0;
        end else begin
          st_nxt.tx_pend = 1'b1;
        end
        st_nxt.tx_empty = 1'b0;
      end
      if (pwdata[`CMD_TX_EN]) begin
        st_nxt.tx_en    = 1'b1;
        st_nxt.tx_pend  = 1'b0;
        st_nxt.tx_empty = 1'b1;
      end
      if (pwdata[`CMD_RX_DIS]) begin
        st_nxt.rx_en = 1'b0;
      end
      if (pwdata[`CMD_RX_EN]) begin
        st_nxt.rx_en = 1'b1;
        st_nxt.hunt  = !wake;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  clock_select_decode u_rx_clk (
    .code     (st_r.clksel[7:4]),
    .rate_set (rate_set),
    .src      (rx_src),
    .baud     (rx_baud)
  );

  clock_select_decode u_tx_clk (
    .code     (st_r.clksel[3:0]),
    .rate_set (rate_set),
    .src      (tx_src),
    .baud     (tx_baud)
  );

  assign prdata                = st_r.prdata;
  assign rx_enable             = st_r.rx_en;
  assign rx_active             = st_r.rx_en || wake;
  assign tx_enable             = st_r.tx_en;
  assign transmit_ready_flag   = tx_ready;
  assign rx_reset              = st_r.rx_rst;
  assign tx_reset              = st_r.tx_rst;
  assign rx_hunt_start         = st_r.hunt;
  assign tx_force_space        = (st_r.brk_st == uart_channel_pkg::BRK_ON);
  assign tx_hold_mark          = (st_r.brk_st == uart_channel_pkg::BRK_MARK);
  assign request_to_send_out_n = st_r.rts_n;
  assign mr_pointer            = st_r.mr_ptr;
  assign timeout_mode          = st_r.tmo_mode;
  assign counter_stop          = st_r.ctr_stop;
  assign counter_ready_clear   = st_r.ctr_rclr;
  assign counter_restart       = st_r.restart;
  assign block_error_mode      = st_r.blk_mode;
  assign break_change          = st_r.brk_chg;
  assign wake_up_mode          = wake;
  assign rx_clk_src            = rx_src;
  assign tx_clk_src            = tx_src;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_mr_pointer_one: assert property (
    cmd_wr && cmd_code == uart_channel_pkg::CMD_PTR_ONE |=> mr_pointer)
    else $error("pointer not moved to mode_register_one");
  chk_rx_reset_clears: assert property (
    cmd_wr && cmd_code == uart_channel_pkg::CMD_RST_RX && !pwdata[0]
    |=> !rx_enable && st_r.rx_cnt == 4'h0 && rx_reset ##1 !rx_reset)
    else $error("receiver reset incomplete");
  chk_error_clear: assert property (
    cmd_wr && cmd_code == uart_channel_pkg::CMD_RST_ERR && !rx_char_valid
    |=> !st_r.overrun)
    else $error("overrun survived error reset");
  chk_break_after_empty: assert property (
    $rose(tx_force_space) |-> $past(st_r.tx_empty) && $past(tx_bit_tick))
    else $error("break began before transmitter empty");
  chk_stop_break_mark: assert property (
    $fell(tx_force_space) |->
    tx_hold_mark || $past(cmd_wr && cmd_code == uart_channel_pkg::CMD_RST_TX))
    else $error("no marking bit after break");
  chk_rts_low: assert property (
    cmd_wr && cmd_code == uart_channel_pkg::CMD_RTS_ON
    |=> !request_to_send_out_n [*1] ##1 1'b1)
    else $error("request to send not asserted");
  chk_timeout_entry: assert property (
    cmd_wr && cmd_code == uart_channel_pkg::CMD_TMO_ON
    |=> timeout_mode && counter_stop && counter_ready_clear ##1 !counter_stop)
    else $error("timeout entry actions missing");
  chk_block_mode_hold: assert property (
    block_error_mode && !(cmd_wr && cmd_code == uart_channel_pkg::CMD_RST_RX)
    |=> block_error_mode)
    else $error("block error mode dropped");
  chk_tx_enable_flags: assert property (
    cmd_wr && pwdata[2] && cmd_code != uart_channel_pkg::CMD_RST_TX
    |=> tx_enable && st_r.tx_empty)
    else $error("enable did not set transmit flags");
  chk_overrun_set: assert property (
    rx_char_valid && rx_enable && !st_r.brk_block && st_r.held &&
    st_r.rx_cnt == 4'h8 && !rx_fifo_read && !cmd_wr |=> st_r.overrun)
    else $error("overrun not flagged");

  cov_break_cycle: cover property (tx_force_space ##[1:50] tx_hold_mark);
  cov_fifo_full:   cover property (status[1] && st_r.held);
  cov_timeout:     cover property (timeout_mode && counter_restart);

endmodule : uart_channel_command_status

`default_nettype wire

//--- verif/uart_channel_command_status_tb.sv
`timescale 1ns/1ps
`default_nettype none

module uart_channel_command_status_tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [3:0]  paddr = 4'h0;
  logic [31:0] pwdata = 32'h0;
  logic        rx_fifo_read = 1'b0;
  logic        tx_load = 1'b0;
  logic        rate_set = 1'b0;
  logic [31:0] prdata, rd;
  logic [15:0] rx_baud, tx_baud;
  logic        rx_active, transmit_ready_flag, rx_hunt_start, break_change, wake_up_mode;
  logic [1:0]  rx_clk_src, tx_clk_src;
  logic        pready, pslverr, slv, rx_enable, tx_enable, rx_reset, tx_reset, mr_pointer;
  logic        tx_force_space, tx_hold_mark, request_to_send_out_n, timeout_mode;
  logic        counter_stop, counter_ready_clear, block_error_mode;
  logic        rx_char_valid, rx_char_break, rx_char_parity_err, rx_char_frame_err;
  logic        rx_char_ad_bit, rx_line_mark_half, peer_rx_load, tx_char_taken;
  logic        tx_char_sent, tx_bit_tick, counter_restart;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          restarts = 0;

  uart_channel_command_status uut (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_char_valid, .rx_char_break, .rx_char_parity_err, .rx_char_frame_err, .rx_char_ad_bit,
    .rx_fifo_read, .rx_line_mark_half, .peer_rx_load, .tx_load, .tx_char_taken, .tx_char_sent,
    .tx_bit_tick, .rate_set, .rx_enable, .rx_active, .tx_enable, .transmit_ready_flag,
    .rx_reset, .tx_reset, .rx_hunt_start, .tx_force_space, .tx_hold_mark,
    .request_to_send_out_n, .mr_pointer, .timeout_mode, .counter_stop, .counter_ready_clear,
    .counter_restart, .block_error_mode, .break_change, .wake_up_mode, .rx_clk_src,
    .tx_clk_src, .rx_baud, .tx_baud
  );

  uart_channel_far_side far (
    .clk_sys, .rx_char_valid, .rx_char_break, .rx_char_parity_err, .rx_char_frame_err,
    .rx_char_ad_bit, .rx_line_mark_half, .peer_rx_load, .tx_char_taken, .tx_char_sent,
    .tx_bit_tick
  );

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (counter_restart === 1'b1) restarts++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One APB transfer; returns at the falling edge after the access edge.
  task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_sys);
  endtask : apb

  task automatic cmd(input logic [7:0] d);
    apb(1'b1, 4'h0, d);
  endtask : cmd

  task automatic st(input logic [7:0] e);
    apb(1'b0, 4'h8, 8'h00);
    chk("status", {24'h0, e}, rd);
  endtask : st

  task automatic strobe(input logic rxr, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (rxr) rx_fifo_read <= 1'b1;
      else tx_load <= 1'b1;
      @(posedge clk_sys);
      rx_fifo_read <= 1'b0;
      tx_load <= 1'b0;
    end
    @(negedge clk_sys);
  endtask : strobe

  task automatic t_reset;
    st(8'h00);
    chk("rts", 1, request_to_send_out_n);
    apb(1'b0, 4'h2, 8'h00);
    chk("slverr", 1, slv);
  endtask : t_reset

  task automatic t_codes;
    logic [7:0] code [7] = '{8'h80, 8'h00, 8'h10, 8'hE0, 8'hF0, 8'hB0, 8'h90};
    logic [1:0] want [7] = '{2'b00, 2'b00, 2'b01, 2'b01, 2'b01, 2'b00, 2'b10};
    for (int i = 0; i < 7; i++) begin
      cmd(code[i]);
      chk("rts_mr", want[i], {request_to_send_out_n, mr_pointer});
    end
  endtask : t_codes

  task automatic t_tx;
    cmd(8'h84);
    chk("rts_txen", 2'b01, {request_to_send_out_n, tx_enable});
    st(8'h0C);
    chk("transmit_ready_flag", 1, transmit_ready_flag);
    strobe(1'b0, 9);
    st(8'h00);
    chk("transmit_ready_flag", 0, transmit_ready_flag);
    cmd(8'h60);
    chk("space", 0, tx_force_space);
    far.drain(8);
    @(negedge clk_sys);
    chk("space", 1, tx_force_space);
    st(8'h0C);
    cmd(8'h70);
    chk("mark", 2'b01, {tx_force_space, tx_hold_mark});
    cmd(8'h08);
    st(8'h00);
    cmd(8'h30);
    chk("txrst", 1, tx_reset);
  endtask : t_tx

  task automatic t_rx;
    cmd(8'h01);
    chk("hunt", 1, rx_hunt_start);
    far.put(4'h2);
    repeat (7) far.put(4'h0);
    st(8'h43);
    repeat (2) far.put(4'h0);
    st(8'h53);
    strobe(1'b1, 1);
    st(8'h13);
    cmd(8'h40);
    st(8'h03);
    cmd(8'h02);
    chk("rxen", 0, rx_enable);
    st(8'h03);
    cmd(8'h20);
    chk("rxrst", 2'b10, {rx_reset, rx_enable});
    st(8'h00);
  endtask : t_rx

  task automatic t_timer;
    cmd(8'hA1);
    chk("tmo", 3'b111, {timeout_mode, counter_stop, counter_ready_clear});
    far.put(4'h0);
    repeat (2) @(posedge clk_sys);
    chk("restart", 1, restarts);
    far.pulse(1'b1);
    repeat (2) @(posedge clk_sys);
    chk("restart", 2, restarts);
    cmd(8'hC0);
    chk("tmo", 0, timeout_mode);
    cmd(8'hD0);
    chk("blk", 1, block_error_mode);
    cmd(8'h40);
    chk("blk", 1, block_error_mode);
    cmd(8'h20);
    chk("blk", 0, block_error_mode);
  endtask : t_timer

  task automatic t_break;
    cmd(8'h01);
    chk("active", 1, rx_active);
    far.put(4'h8);
    st(8'h81);
    chk("brkchg", 1, break_change);
    cmd(8'h50);
    chk("brkchg", 0, break_change);
    far.put(4'h0);
    st(8'h81);
    far.pulse(1'b0);
    @(negedge clk_sys);
    chk("brkchg", 1, break_change);
    apb(1'b1, 4'hC, 8'h18);
    cmd(8'h02);
    chk("wake", 2'b11, {wake_up_mode, rx_active});
    far.put(4'h1);
    strobe(1'b1, 1);
    st(8'h21);
    apb(1'b0, 4'hC, 8'h00);
    chk("mode1", 8'h18, rd);
  endtask : t_break

  task automatic t_clk;
    apb(1'b1, 4'h4, 8'hFE);
    chk("src", 4'hE, {rx_clk_src, tx_clk_src});
    apb(1'b1, 4'h4, 8'hDF);
    chk("src", 4'h7, {rx_clk_src, tx_clk_src});
    chk("baud", 0, rx_baud);
    apb(1'b1, 4'h4, 8'h00);
    chk("baud", 50, rx_baud);
    chk("txbaud", 50, tx_baud);
    @(posedge clk_sys);
    rate_set <= 1'b1;
    @(negedge clk_sys);
    chk("baud", 75, rx_baud);
  endtask : t_clk

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_codes();
    t_tx();
    t_rx();
    t_timer();
    t_break();
    t_clk();
    end_of_test();
  end
endmodule : uart_channel_command_status_tb

`default_nettype wire

//--- verif/uart_channel_far_side.sv
`timescale 1ns/1ps
`default_nettype none

module uart_channel_far_side (
  input  wire logic clk_sys,
  output logic      rx_char_valid,
  output logic      rx_char_break,
  output logic      rx_char_parity_err,
  output logic      rx_char_frame_err,
  output logic      rx_char_ad_bit,
  output logic      rx_line_mark_half,
  output logic      peer_rx_load,
  output logic      tx_char_taken,
  output logic      tx_char_sent,
  output logic      tx_bit_tick
);
  initial begin
    {rx_char_valid, rx_char_break, rx_char_parity_err, rx_char_frame_err} = 4'h0;
    {rx_char_ad_bit, rx_line_mark_half, peer_rx_load} = 3'h0;
    {tx_char_taken, tx_char_sent, tx_bit_tick} = 3'h0;
  end

  // Qualifiers mean nothing outside the strobe, so they are inverted afterwards.
  task automatic put(input logic [3:0] q);
    @(posedge clk_sys);
    {rx_char_break, rx_char_parity_err, rx_char_frame_err, rx_char_ad_bit} <= q;
    rx_char_valid <= 1'b1;
    @(posedge clk_sys);
    rx_char_valid <= 1'b0;
    {rx_char_break, rx_char_parity_err, rx_char_frame_err, rx_char_ad_bit} <= ~q;
  endtask : put

  // One-cycle pulse on the peer-load strobe or on the line-mark strobe.
  task automatic pulse(input logic peer);
    @(posedge clk_sys);
    if (peer) peer_rx_load <= 1'b1;
    else rx_line_mark_half <= 1'b1;
    @(posedge clk_sys);
    peer_rx_load <= 1'b0;
    rx_line_mark_half <= 1'b0;
  endtask : pulse

  // Sends n queued characters one after another, then gives one bit time tick.
  task automatic drain(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      tx_char_taken <= 1'b1;
      @(posedge clk_sys);
      tx_char_taken <= 1'b0;
      tx_char_sent <= 1'b1;
      @(posedge clk_sys);
      tx_char_sent <= 1'b0;
    end
    @(posedge clk_sys);
    tx_bit_tick <= 1'b1;
    @(posedge clk_sys);
    tx_bit_tick <= 1'b0;
  endtask : drain
endmodule : uart_channel_far_side

`default_nettype wire
